/* logic/adc_ctrl_consts.svh */
// Purpose: Offsets, fields, reset values and timing counts of the converter control block
// Assumes: Core clock of 100 MHz doubles as the master clock
// Notes: Included by bare name
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH

// ==========================================================
// Register map (byte addresses)
`define REG_STATUS 8'h00
`define REG_MASK 8'h04
`define REG_RESULT 8'h08
`define REG_STATE 8'h0C

// ==========================================================
// Fields
`define EVT_W 2
`define EVT_EOC 0
`define EVT_CAL 1
`define WORD_W 16
`define MSB_MASK 16'h8000
`define STATUS_RST 2'h0
`define MASK_RST 2'h0

// ==========================================================
// Timing
`define CLK_PERIOD_NS 10
`define CAL_CYCLES 34584480
`define CONV_CYCLES 40
`define HOLD_MIN_NS 50
`define HOLD_MIN_CYCLES (1 + (`HOLD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* logic/adc_pkg.sv */
// Purpose: Types shared by the converter control block
// Assumes: Nothing beyond the consts header
// Notes: Pin struct order fixes the synchroniser bit order
`default_nettype none

package adc_pkg;
    typedef enum logic [1:0] {ST_CAL, ST_IDLE, ST_CONV, ST_SLEEP} adc_state_e;

    typedef struct packed {
        logic rst_n;
        logic sleep_n;
        logic code_sel;
        logic lr_sel;
        logic hold;
        logic sclk;
    } ctrl_pins_s;
endpackage

`default_nettype wire

/* logic/stereo_sar_adc_ctrl.sv */
// Purpose: Control and serial output logic of a two-channel SAR audio converter
// Assumes: core_clk is the master clock; pins come from outside and are synchronised
// Notes: Registers over AHB-Lite, zero wait states
//
// What this block does
// - A falling edge of the hold strobe freezes the input and starts a conversion.
// - The channel-select level at conversion end picks the channel for the next one.
// - While sleep request is low the block is quiescent and does not convert.
// - Calibration results survive sleep, so waking does not recalibrate.
// - A conversion is accepted as soon as sleep request returns high.
// - Format select high gives two's complement, low gives offset binary.
// - Serial output changes only on shift clock falling edges, one bit per edge, or when reset clears it.
// - While reset pin is low the converter logic is held in reset; synchronisers, bus registers and interrupt are not.
// - Release of reset runs a calibration of exactly 34,584,480 master clocks.
// - Calibration status is low during calibration and high once it ends.
// - At conversion end exactly one tracking flag falls, for the next channel.
// - Two sample/hold controls let external stages sample both channels together.
// - Mid-scale step lies between 011..1 and 100..0 codes in offset binary, between 111..1 and 000..0 in two's complement.
//
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`include "adc_ctrl_consts.svh"
`default_nettype none

module stereo_sar_adc_ctrl #(
    parameter int unsigned CAL_CYCLES = `CAL_CYCLES,
    parameter int unsigned CONV_CYCLES = `CONV_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Converter pins and front end
    input wire adc_pkg::ctrl_pins_s pins,
    input wire logic [`WORD_W-1:0] raw_code,
    output logic serial_result_out,
    output logic calibration_done,
    output logic left_tracking_flag,
    output logic right_tracking_flag,
    output logic simul_sample_ctrl_a,
    output logic simul_sample_ctrl_b,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Interrupt
    output logic irq
);
    import adc_pkg::*;

    localparam int PIN_W = $bits(ctrl_pins_s);
    localparam int CW = $clog2(CAL_CYCLES + 1);
    localparam logic [CW-1:0] CAL_LAST = CW'(CAL_CYCLES - 1);
    localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);
    localparam int BW = $clog2(`WORD_W + 1);

    generate
        if (CAL_CYCLES < 1 || CONV_CYCLES < 1 || CONV_CYCLES > CAL_CYCLES) begin : g_bad
            $error("CAL_CYCLES and CONV_CYCLES must be at least 1, CONV not above CAL");
        end
    endgenerate

    // ==========================================================
    // Pin synchronisers
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_now;
    logic [PIN_W-1:0] pin_old;
    ctrl_pins_s s_now;
    ctrl_pins_s s_prev;
    assign pin_raw = pins;

    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_sync
            logic s1;
            logic s2;
            logic s3;
            // First stage feeds only the second
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                end else begin
                    s1 <= pin_raw[gi];
                    s2 <= s1;
                    s3 <= s2;
                end
            end
            assign pin_now[gi] = s2;
            assign pin_old[gi] = s3;
        end
    endgenerate

    assign s_now = ctrl_pins_s'(pin_now);
    assign s_prev = ctrl_pins_s'(pin_old);

    logic hold_fall;
    logic sclk_fall;
    logic dev_rst;
    assign hold_fall = s_prev.hold & ~s_now.hold;
    assign sclk_fall = s_prev.sclk & ~s_now.sclk;
    // Synced reset pin low holds the sequencer, outputs and shifter below in reset, not the AHB-Lite slave
    assign dev_rst = sys_rst | ~s_now.rst_n;

    // ==========================================================
    // Sequencer
    adc_state_e state;
    logic [CW-1:0] cnt;
    logic cal_ok;
    logic conv_last;
    logic cal_last;
    logic acq_left;

    assign cal_last = (state == ST_CAL) && s_now.sleep_n && (cnt == CAL_LAST);
    assign conv_last = (state == ST_CONV) && s_now.sleep_n && (cnt == CONV_LAST);

    always_ff @(posedge core_clk) begin
        if (dev_rst) begin
            state <= ST_CAL;
            cnt <= '0;
            cal_ok <= 1'b0;
        end else begin
            case (state)
                ST_CAL: begin
                    // Sleep only pauses the count, nothing is lost
                    if (cal_last) begin
                        state <= ST_IDLE;
                        cal_ok <= 1'b1;
                        cnt <= '0;
                    end else if (s_now.sleep_n) begin
                        cnt <= cnt + 1'b1;
                    end
                end
                ST_IDLE: begin
                    if (!s_now.sleep_n) begin
                        state <= ST_SLEEP;
                    end else if (hold_fall) begin
                        state <= ST_CONV;
                        cnt <= '0;
                    end
                end
                ST_CONV: begin
                    // Sleep aborts the conversion in flight
                    if (!s_now.sleep_n) begin
                        state <= ST_SLEEP;
                    end else if (conv_last) begin
                        state <= ST_IDLE;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                ST_SLEEP: begin
                    // Coefficients kept, no recalibration on wake
                    if (s_now.sleep_n) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_CAL;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (dev_rst) begin
            calibration_done <= 1'b0;
        end else begin
            calibration_done <= cal_ok | cal_last;
        end
    end

    // ==========================================================
    // Channel, tracking and sample/hold outputs
    always_ff @(posedge core_clk) begin
        if (dev_rst) begin
            acq_left <= 1'b1;
            left_tracking_flag <= 1'b1;
            right_tracking_flag <= 1'b1;
        end else if (conv_last) begin
            acq_left <= s_now.lr_sel;
            left_tracking_flag <= ~s_now.lr_sel;
            right_tracking_flag <= s_now.lr_sel;
        end else if (state == ST_IDLE && s_now.sleep_n && hold_fall) begin
            left_tracking_flag <= 1'b1;
            right_tracking_flag <= 1'b1;
        end
    end

    // Both controls move together so external stages hold at one instant
    always_ff @(posedge core_clk) begin
        if (dev_rst) begin
            simul_sample_ctrl_a <= 1'b0;
            simul_sample_ctrl_b <= 1'b0;
        end else if (state == ST_IDLE && s_now.sleep_n && hold_fall) begin
            simul_sample_ctrl_a <= 1'b1;
            simul_sample_ctrl_b <= 1'b1;
        end else if (conv_last || !s_now.sleep_n) begin
            simul_sample_ctrl_a <= 1'b0;
            simul_sample_ctrl_b <= 1'b0;
        end
    end

    // ==========================================================
    // Result coding and serial shifter
    logic [`WORD_W-1:0] coded;
    logic [`WORD_W-1:0] result;
    logic [`WORD_W-1:0] shreg;
    logic [BW-1:0] bits_left;

    // Front end code is offset binary, 7FFF to 8000 at mid-scale
    assign coded = s_now.code_sel ? (raw_code ^ `MSB_MASK) : raw_code;

    // Load wins over a shift clock edge in the same cycle
    always_ff @(posedge core_clk) begin
        if (dev_rst) begin
            result <= '0;
            shreg <= '0;
            bits_left <= '0;
            serial_result_out <= 1'b0;
        end else if (conv_last) begin
            result <= coded;
            shreg <= coded;
            bits_left <= BW'(`WORD_W);
        end else if (sclk_fall && bits_left != '0) begin
            serial_result_out <= shreg[`WORD_W-1];
            shreg <= {shreg[`WORD_W-2:0], 1'b0};
            bits_left <= bits_left - 1'b1;
        end
    end

    // ==========================================================
    // AHB-Lite slave and interrupt
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [`EVT_W-1:0] status;
    logic [`EVT_W-1:0] mask;
    logic [`EVT_W-1:0] evt;
    logic [`EVT_W-1:0] clr;
    logic [`EVT_W-1:0] next_status;

    assign evt = {cal_last, conv_last};
    assign clr = (wr_pend && wr_addr == `REG_STATUS) ? hwdata[`EVT_W-1:0] : '0;
    // Set beats clear in the same cycle
    assign next_status = (status & ~clr) | evt;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend <= hsel && htrans[1] && hready && hwrite;
            wr_addr <= haddr[7:0];
            if (hsel && htrans[1] && hready && !hwrite) begin
                case (haddr[7:0])
                    `REG_STATUS: hrdata <= {30'h0, status};
                    `REG_MASK: hrdata <= {30'h0, mask};
                    `REG_RESULT: hrdata <= {16'h0000, result};
                    `REG_STATE: hrdata <= {28'h0, acq_left, state == ST_SLEEP,
                                           state == ST_CONV, cal_ok};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            status <= `STATUS_RST;
            mask <= `MASK_RST;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            if (wr_pend && wr_addr == `REG_MASK) begin
                mask <= hwdata[`EVT_W-1:0];
            end
            irq <= |(next_status & mask);
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_hold_starts;
        (state == ST_IDLE && s_now.sleep_n && hold_fall && s_now.rst_n)
            |=> (state == ST_CONV && cnt == '0 && simul_sample_ctrl_a);
    endproperty
    a_hold_starts: assert property (p_hold_starts) else $error("hold fall ignored");

    property p_chan_pick;
        (conv_last && s_now.rst_n) |=> (acq_left == $past(s_now.lr_sel));
    endproperty
    a_chan_pick: assert property (p_chan_pick) else $error("channel not latched");

    property p_sleep_quiet;
        (!s_now.sleep_n && s_now.rst_n) |=> (state != ST_CONV && !simul_sample_ctrl_a);
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("converting in sleep");

    property p_keep_cal;
        (state == ST_SLEEP && s_now.rst_n) |=> calibration_done;
    endproperty
    a_keep_cal: assert property (p_keep_cal) else $error("calibration lost in sleep");

    property p_wake;
        (state == ST_SLEEP && s_now.sleep_n && s_now.rst_n) |=> (state == ST_IDLE);
    endproperty
    a_wake: assert property (p_wake) else $error("slow wake");

    property p_coding;
        (conv_last && s_now.rst_n) |=> (result ==
            ($past(s_now.code_sel) ? ($past(raw_code) ^ `MSB_MASK) : $past(raw_code)));
    endproperty
    a_coding: assert property (p_coding) else $error("wrong output coding");

    property p_shift_edge;
        // A pin reset clears the output without a shift clock edge
        $changed(serial_result_out) |-> ($past(sclk_fall) || $past(dev_rst));
    endproperty
    a_shift_edge: assert property (p_shift_edge) else $error("data moved off edge");

    property p_reset_hold;
        !s_now.rst_n |=> (state == ST_CAL && cnt == '0 && !calibration_done);
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("reset pin ignored");

    property p_cal_end;
        (cal_last && s_now.rst_n) |=> (calibration_done && state == ST_IDLE && !$past(cal_ok));
    endproperty
    a_cal_end: assert property (p_cal_end) else $error("calibration end wrong");

    property p_cal_low;
        (state == ST_CAL) |-> !calibration_done;
    endproperty
    a_cal_low: assert property (p_cal_low) else $error("status high in calibration");

    property p_one_flag;
        (conv_last && s_now.rst_n) |=> ($fell(left_tracking_flag) != $fell(right_tracking_flag));
    endproperty
    a_one_flag: assert property (p_one_flag) else $error("tracking flags wrong");

    property p_sh_pair;
        simul_sample_ctrl_a == simul_sample_ctrl_b;
    endproperty
    a_sh_pair: assert property (p_sh_pair) else $error("sample controls split");

endmodule // stereo_sar_adc_ctrl

`default_nettype wire

/* verification/adc_link_partner.sv */
// Purpose: Timing controller and serial receiver facing the converter pins
// Assumes: Shift clock of 125 ns period, made only inside frames
// Notes: Tasks are called by the bench through the instance
`include "adc_ctrl_consts.svh"
`default_nettype none

module adc_link_partner (
    // Clock
    input wire logic core_clk,
    // Levels chosen by the bench
    input wire logic rst_n,
    input wire logic sleep_n,
    input wire logic code_sel,
    input wire logic lr_sel,
    // Serial data from the converter
    input wire logic serial_result_out,
    // Pins to the converter
    output adc_pkg::ctrl_pins_s pins,
    output logic [15:0] rx_word
);
    import adc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic hold = 1'b1;
    logic sclk = 1'b1;

    // The master clock is the bench's free running core_clk
    assign pins = {rst_n, sleep_n, code_sel, lr_sel, hold, sclk};

    // ==========================================================
    // Hold strobe
    // Kept low two cycles past the minimum, as sampling may miss short pulses
    task automatic strobe();
        @(posedge core_clk);
        hold <= 1'b0;
        repeat (`HOLD_MIN_CYCLES + 2) @(posedge core_clk);
        hold <= 1'b1;
    endtask

    // ==========================================================
    // Frame receiver
    // Shift clock idles high and stands still between frames
    task automatic shift16();
        rx_word = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            #62.5 sclk = 1'b0;
            #62.5 sclk = 1'b1;
            rx_word = {rx_word[14:0], serial_result_out};
        end
    endtask
endmodule // adc_link_partner

`default_nettype wire

/* verification/tb_top.sv */
// Purpose: Self-checking bench of the converter control block
// Assumes: Calibration shortened to 100 cycles
// Notes: Registers reached over AHB-Lite single word transfers
`include "adc_ctrl_consts.svh"
`default_nettype none

module tb_top;
    import adc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int unsigned CAL = 100;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic rst_n = 1'b1;
    logic sleep_n = 1'b1;
    logic code_sel = 1'b0;
    logic lr_sel = 1'b0;
    logic [15:0] raw_code = 16'h0000;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout, hresp, irq, serial_result_out, calibration_done;
    logic left_tracking_flag, right_tracking_flag, simul_sample_ctrl_a, simul_sample_ctrl_b;
    logic [31:0] hrdata, rd;
    logic [15:0] rx_word;
    ctrl_pins_s pins;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;

    always #5 core_clk = ~core_clk;
    assign hready = hreadyout;

    stereo_sar_adc_ctrl #(.CAL_CYCLES(CAL), .CONV_CYCLES(`CONV_CYCLES)) u_stereo_sar_adc_ctrl (
        .core_clk(core_clk), .sys_rst(sys_rst), .pins(pins), .raw_code(raw_code),
        .serial_result_out(serial_result_out), .calibration_done(calibration_done),
        .left_tracking_flag(left_tracking_flag), .right_tracking_flag(right_tracking_flag),
        .simul_sample_ctrl_a(simul_sample_ctrl_a), .simul_sample_ctrl_b(simul_sample_ctrl_b),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .irq(irq));

    adc_link_partner u_adc_link_partner (
        .core_clk(core_clk), .rst_n(rst_n), .sleep_n(sleep_n), .code_sel(code_sel),
        .lr_sel(lr_sel), .serial_result_out(serial_result_out), .pins(pins),
        .rx_word(rx_word));

    // ==========================================================
    // Reporting
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Ends a hang; the ceiling is several times the expected run
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            test_done();
        end
    end

    // ==========================================================
    // Bus master, entered just after a rising edge
    task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                            output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge core_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hready !== 1'b1);
        q = hrdata;
        check(hresp, 1'b0);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        ahb_xfer(1'b0, a, 32'h0, rd);
        check(rd, exp);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        ahb_xfer(1'b1, a, d, rd);
    endtask

    // ==========================================================
    // One conversion and its frame
    task automatic do_conv(input logic lr, input logic code, input logic [15:0] raw);
        lr_sel <= lr;
        code_sel <= code;
        raw_code <= raw;
        u_adc_link_partner.strobe();
        check({simul_sample_ctrl_a, simul_sample_ctrl_b}, 2'h3);
        for (int i = 0; i < `CONV_CYCLES + 20; i++) begin
            if ((left_tracking_flag & right_tracking_flag) !== 1'b1) break;
            @(posedge core_clk);
        end
        check({left_tracking_flag, right_tracking_flag}, lr ? 2'h1 : 2'h2);
        u_adc_link_partner.shift16();
        @(posedge core_clk);
        check(rx_word, code ? {~raw[15], raw[14:0]} : raw);
        rd_chk(`REG_RESULT, code ? {~raw[15], raw[14:0]} : raw);
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        check({calibration_done, left_tracking_flag, right_tracking_flag}, 3'h3);
        rd_chk(`REG_MASK, 32'h0);
        rd_chk(32'h10, 32'h0);
        repeat (CAL - 3) @(posedge core_clk);
        check(calibration_done, 1'b0);
        @(posedge core_clk);
        check(calibration_done, 1'b1);
        $display("test calibration done");

        rd_chk(`REG_STATUS, 32'h2);
        check(irq, 1'b0);
        wr(`REG_MASK, 32'h2);
        repeat (2) @(posedge core_clk);
        check(irq, 1'b1);
        wr(`REG_STATUS, 32'h2);
        repeat (2) @(posedge core_clk);
        check(irq, 1'b0);
        rd_chk(`REG_STATUS, 32'h0);
        $display("test interrupt done");

        // Both codings, both channels, both sides of mid-scale
        for (int i = 0; i < 4; i++) begin
            do_conv(~i[0], i[1], i[0] ? 16'h8000 : 16'h7FFF);
        end
        $display("test conversion done");

        wr(`REG_STATUS, 32'h3);
        sleep_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        u_adc_link_partner.strobe();
        repeat (`CONV_CYCLES + 10) @(posedge core_clk);
        check(simul_sample_ctrl_a, 1'b0);
        rd_chk(`REG_STATUS, 32'h0);
        sleep_n <= 1'b1;
        do_conv(1'b1, 1'b0, 16'h1234);
        check(calibration_done, 1'b1);
        $display("test sleep done");

        rst_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        check({calibration_done, left_tracking_flag, right_tracking_flag}, 3'h3);
        rst_n <= 1'b1;
        repeat (CAL + 2) @(posedge core_clk);
        check(calibration_done, 1'b0);
        @(posedge core_clk);
        check(calibration_done, 1'b1);
        $display("test pin reset done");
        test_done();
    end
endmodule // tb_top

`default_nettype wire
